// >>> design/sip_pkg.sv
// package: register map, field layout and types of the ingress priority table control
//
// Functional notes
// - vlan table status bit 0 is pending while a vlan table access runs
// - every write to the priority command register launches one table access
// - command bit 7 chooses direction: one reads, zero writes
// - command bits 5:0 pick the table entry; bit 6 is reserved
// - host loads write data first; pending stays up until the entry is stored
// - after pending clears, the read data register holds the entry priority
// - table turns the received tos/cs field into a 3-bit priority
// - table is not cleared at reset; host should write every entry
// - config bit 17 lets mld detection accept extra next header values
// - config bit 16 makes mld detection ignore the hop-by-hop next header
// - config bit 15 makes vlan rules use the port default vid
// - config bit 14 allows vlan tag priority as queue source
// - config bit 13 allows monitored packets back to their source port
// - config bits 12:10 are the monitor port map
// - config bit 9 allows ip tos or traffic class as queue source
// - config bit 8 enables mld detection towards the monitor ports
// - config bit 7 enables igmp detection towards the monitor ports
// - config bit 6 makes read-cleared counters load the test value
// - config bit 5 lets lookup table priority pick the queue
// - precedence bit picks tos precedence when set, else the table
package sip_pkg;

    // register indexes; byte address is four times the index
    localparam logic [13:0] SIP_IDX_VLAN_STS = 14'h1810;
    localparam logic [13:0] SIP_IDX_PT_CMD = 14'h1811;
    localparam logic [13:0] SIP_IDX_PT_WDATA = 14'h1812;
    localparam logic [13:0] SIP_IDX_PT_RDATA = 14'h1813;
    localparam logic [13:0] SIP_IDX_PT_STS = 14'h1814;
    localparam logic [13:0] SIP_IDX_GCFG = 14'h1840;
    localparam int SIP_ADDR_W = 16;

    // command register fields
    localparam int SIP_CMD_DIR_BIT = 7;
    localparam int SIP_CMD_IDX_LSB = 0;
    localparam int SIP_TBL_IDX_W = 6;
    localparam int SIP_PRIO_W = 3;
    localparam logic [31:0] SIP_CMD_MASK = 32'h0000_00BF;

    // global ingress config field positions
    localparam int SIP_G_OTHER_NH = 17;
    localparam int SIP_G_ANY_HBH = 16;
    localparam int SIP_G_VLAN_DIS = 15;
    localparam int SIP_G_USE_TAG = 14;
    localparam int SIP_G_ECHO = 13;
    localparam int SIP_G_MON_LSB = 10;
    localparam int SIP_G_MON_W = 3;
    localparam int SIP_G_USE_IP = 9;
    localparam int SIP_G_MLD = 8;
    localparam int SIP_G_IGMP = 7;
    localparam int SIP_G_CNT_TEST = 6;
    localparam int SIP_G_DA_PRIO = 5;
    localparam int SIP_G_USE_PREC = 2;
    localparam logic [31:0] SIP_GCFG_RESET = 32'h0000_0004;

    // value a read-cleared counter takes in test mode
    localparam logic [31:0] SIP_CNT_TEST_VALUE = 32'h07FF_FFFC;
    localparam logic [31:0] SIP_CNT_CLEAR_VALUE = 32'h0000_0000;

    // tos octet: table index in 7:2, precedence in 7:5
    localparam int SIP_TOS_IDX_LSB = 2;
    localparam int SIP_TOS_PREC_LSB = 5;

    typedef enum logic [2:0]
    {
        SIP_SEL_NONE = 3'b000,
        SIP_SEL_VLAN_STS = 3'b001,
        SIP_SEL_PT_CMD = 3'b010,
        SIP_SEL_PT_WDATA = 3'b011,
        SIP_SEL_PT_RDATA = 3'b100,
        SIP_SEL_PT_STS = 3'b101,
        SIP_SEL_GCFG = 3'b110
    } sip_sel_t;

    typedef enum logic [1:0]
    {
        SIP_ST_IDLE = 2'b00,
        SIP_ST_WR_STORE = 2'b01,
        SIP_ST_RD_ADDR = 2'b10,
        SIP_ST_RD_CAPT = 2'b11
    } sip_state_t;

    // settings handed to the switch datapath
    typedef struct packed
    {
        logic other_mld_nh;
        logic any_hbh_nh;
        logic vlan_disable;
        logic use_tag;
        logic monitor_echo;
        logic [2:0] monitor_ports;
        logic use_ip;
        logic mld_monitor;
        logic igmp_monitor;
        logic counter_test_mode;
        logic da_highest_prio;
        logic use_precedence;
    } sip_gcfg_t;

    // byte address to register select; misaligned or unknown is none
    function automatic sip_sel_t sip_decode(input logic [SIP_ADDR_W-1:0] addr);
        sip_sel_t sel;
        sel = SIP_SEL_NONE;
        if (addr[1:0] == 2'h0)
        begin
            case (addr[SIP_ADDR_W-1:2])
                SIP_IDX_VLAN_STS: sel = SIP_SEL_VLAN_STS;
                SIP_IDX_PT_CMD: sel = SIP_SEL_PT_CMD;
                SIP_IDX_PT_WDATA: sel = SIP_SEL_PT_WDATA;
                SIP_IDX_PT_RDATA: sel = SIP_SEL_PT_RDATA;
                SIP_IDX_PT_STS: sel = SIP_SEL_PT_STS;
                SIP_IDX_GCFG: sel = SIP_SEL_GCFG;
                default: sel = SIP_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    function automatic sip_gcfg_t sip_word_to_gcfg(input logic [31:0] w);
        sip_gcfg_t g;
        g.other_mld_nh = w[SIP_G_OTHER_NH];
        g.any_hbh_nh = w[SIP_G_ANY_HBH];
        g.vlan_disable = w[SIP_G_VLAN_DIS];
        g.use_tag = w[SIP_G_USE_TAG];
        g.monitor_echo = w[SIP_G_ECHO];
        g.monitor_ports = w[SIP_G_MON_LSB +: SIP_G_MON_W];
        g.use_ip = w[SIP_G_USE_IP];
        g.mld_monitor = w[SIP_G_MLD];
        g.igmp_monitor = w[SIP_G_IGMP];
        g.counter_test_mode = w[SIP_G_CNT_TEST];
        g.da_highest_prio = w[SIP_G_DA_PRIO];
        g.use_precedence = w[SIP_G_USE_PREC];
        return g;
    endfunction

    function automatic logic [31:0] sip_gcfg_to_word(input sip_gcfg_t g);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SIP_G_OTHER_NH] = g.other_mld_nh;
        w[SIP_G_ANY_HBH] = g.any_hbh_nh;
        w[SIP_G_VLAN_DIS] = g.vlan_disable;
        w[SIP_G_USE_TAG] = g.use_tag;
        w[SIP_G_ECHO] = g.monitor_echo;
        w[SIP_G_MON_LSB +: SIP_G_MON_W] = g.monitor_ports;
        w[SIP_G_USE_IP] = g.use_ip;
        w[SIP_G_MLD] = g.mld_monitor;
        w[SIP_G_IGMP] = g.igmp_monitor;
        w[SIP_G_CNT_TEST] = g.counter_test_mode;
        w[SIP_G_DA_PRIO] = g.da_highest_prio;
        w[SIP_G_USE_PREC] = g.use_precedence;
        return w;
    endfunction

endpackage

// >>> design/sip_table_ram.sv
// two-port table memory: host port read/write, lookup port read only
`timescale 1ns/1ps
module sip_table_ram #(
    parameter int DATA_W = 3,
    parameter int ADDR_W = 6
) (
    // clock
    input wire logic clk,
    // host port
    input wire logic a_we,
    input wire logic [ADDR_W-1:0] a_addr,
    input wire logic [DATA_W-1:0] a_wdata,
    output logic [DATA_W-1:0] a_rdata,
    // lookup port
    input wire logic [ADDR_W-1:0] b_addr,
    output logic [DATA_W-1:0] b_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset on the array: contents are undefined until the host writes them
    always_ff @(posedge clk)
    begin
        if (a_we)
        begin
            mem[a_addr] <= a_wdata;
        end
    end

    // registered read on the host port
    always_ff @(posedge clk)
    begin
        a_rdata <= mem[a_addr];
    end

    // registered read on the lookup port
    always_ff @(posedge clk)
    begin
        b_rdata <= mem[b_addr];
    end
endmodule

// >>> design/sip_ctrl.sv
// ingress priority table control: apb registers, table access engine, lookup
`timescale 1ns/1ps
module sip_ctrl #(
    parameter int TBL_IDX_W = sip_pkg::SIP_TBL_IDX_W,
    parameter int PRIO_W = sip_pkg::SIP_PRIO_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sip_pkg::SIP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // vlan table engine progress
    input wire logic vlan_cmd_start,
    input wire logic vlan_cmd_done,
    // datapath tos lookup
    input wire logic lookup_valid,
    input wire logic [7:0] lookup_tos,
    output logic ip_prio_valid,
    output logic [PRIO_W-1:0] ip_prio,
    // settings towards the datapath
    output sip_pkg::sip_gcfg_t gcfg,
    output logic [31:0] cnt_clear_value
);
    sip_pkg::sip_state_t state_q;
    sip_pkg::sip_sel_t sel;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic wr_commit;
    logic cmd_launch;
    logic dir_read_q;
    logic [TBL_IDX_W-1:0] tbl_idx_q;
    logic [PRIO_W-1:0] wdata_q;
    logic [PRIO_W-1:0] rdata_q;
    logic prio_pending_q;
    logic vlan_pending_q;
    sip_pkg::sip_gcfg_t gcfg_q;
    logic [31:0] cnt_clear_q;
    logic mem_we;
    logic [PRIO_W-1:0] mem_a_rdata;
    logic [PRIO_W-1:0] mem_b_rdata;
    logic lookup_dly_q;
    logic [PRIO_W-1:0] prec_dly_q;
    logic ip_prio_valid_q;
    logic [PRIO_W-1:0] ip_prio_q;

    assign sel = sip_pkg::sip_decode(paddr);
    // a write takes effect only on the edge that completes the transfer
    assign wr_commit = psel && penable && pready_q && pwrite;
    assign cmd_launch = wr_commit && (sel == sip_pkg::SIP_SEL_PT_CMD);

    // one wait state so read data can come out of a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && (sel == sip_pkg::SIP_SEL_NONE);
        end
    end

    // read mux, sampled one cycle before pready is seen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (psel && penable && !pready_q && !pwrite)
        begin
            unique case (sel)
                sip_pkg::SIP_SEL_VLAN_STS: prdata_q <= {31'h0000_0000, vlan_pending_q};
                sip_pkg::SIP_SEL_PT_CMD:
                    prdata_q <= {24'h00_0000, dir_read_q, 1'b0, tbl_idx_q};
                sip_pkg::SIP_SEL_PT_WDATA: prdata_q <= {29'h0000_0000, wdata_q};
                sip_pkg::SIP_SEL_PT_RDATA: prdata_q <= {29'h0000_0000, rdata_q};
                sip_pkg::SIP_SEL_PT_STS: prdata_q <= {31'h0000_0000, prio_pending_q};
                sip_pkg::SIP_SEL_GCFG: prdata_q <= sip_pkg::sip_gcfg_to_word(gcfg_q);
                sip_pkg::SIP_SEL_NONE: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // command register fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_read_q <= 1'b0;
            tbl_idx_q <= '0;
        end
        else if (cmd_launch)
        begin
            dir_read_q <= pwdata[sip_pkg::SIP_CMD_DIR_BIT];
            tbl_idx_q <= pwdata[sip_pkg::SIP_CMD_IDX_LSB +: TBL_IDX_W];
        end
    end

    // write data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdata_q <= '0;
        end
        else if (wr_commit && (sel == sip_pkg::SIP_SEL_PT_WDATA))
        begin
            wdata_q <= pwdata[PRIO_W-1:0];
        end
    end

    // global ingress config; only the bits the datapath uses are stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gcfg_q <= sip_pkg::sip_word_to_gcfg(sip_pkg::SIP_GCFG_RESET);
        end
        else if (wr_commit && (sel == sip_pkg::SIP_SEL_GCFG))
        begin
            gcfg_q <= sip_pkg::sip_word_to_gcfg(pwdata);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_clear_q <= sip_pkg::SIP_CNT_CLEAR_VALUE;
        end
        else
        begin
            cnt_clear_q <= gcfg_q.counter_test_mode ? sip_pkg::SIP_CNT_TEST_VALUE
                                                     : sip_pkg::SIP_CNT_CLEAR_VALUE;
        end
    end

    // table access sequencer; a new command restarts it from the top
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= sip_pkg::SIP_ST_IDLE;
        end
        else if (cmd_launch)
        begin
            state_q <= pwdata[sip_pkg::SIP_CMD_DIR_BIT] ? sip_pkg::SIP_ST_RD_ADDR
                                                         : sip_pkg::SIP_ST_WR_STORE;
        end
        else
        begin
            unique case (state_q)
                sip_pkg::SIP_ST_IDLE: state_q <= sip_pkg::SIP_ST_IDLE;
                sip_pkg::SIP_ST_WR_STORE: state_q <= sip_pkg::SIP_ST_IDLE;
                sip_pkg::SIP_ST_RD_ADDR: state_q <= sip_pkg::SIP_ST_RD_CAPT;
                sip_pkg::SIP_ST_RD_CAPT: state_q <= sip_pkg::SIP_ST_IDLE;
            endcase
        end
    end

    assign mem_we = (state_q == sip_pkg::SIP_ST_WR_STORE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q <= '0;
        end
        else if (state_q == sip_pkg::SIP_ST_RD_CAPT)
        begin
            rdata_q <= mem_a_rdata;
        end
    end

    // pending flag; a launch on the finishing edge keeps it set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prio_pending_q <= 1'b0;
        end
        else if (cmd_launch)
        begin
            prio_pending_q <= 1'b1;
        end
        else if ((state_q == sip_pkg::SIP_ST_WR_STORE) || (state_q == sip_pkg::SIP_ST_RD_CAPT))
        begin
            prio_pending_q <= 1'b0;
        end
    end

    // vlan pending, start wins over done
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vlan_pending_q <= 1'b0;
        end
        else if (vlan_cmd_start)
        begin
            vlan_pending_q <= 1'b1;
        end
        else if (vlan_cmd_done)
        begin
            vlan_pending_q <= 1'b0;
        end
    end

    sip_table_ram #(
        .DATA_W(PRIO_W),
        .ADDR_W(TBL_IDX_W)
    ) u_ram (
        .clk(pclk),
        .a_we(mem_we),
        .a_addr(tbl_idx_q),
        .a_wdata(wdata_q),
        .a_rdata(mem_a_rdata),
        .b_addr(lookup_tos[sip_pkg::SIP_TOS_IDX_LSB +: TBL_IDX_W]),
        .b_rdata(mem_b_rdata)
    );

    // precedence delayed to line up with the table read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lookup_dly_q <= 1'b0;
            prec_dly_q <= '0;
        end
        else
        begin
            lookup_dly_q <= lookup_valid;
            prec_dly_q <= lookup_tos[sip_pkg::SIP_TOS_PREC_LSB +: PRIO_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ip_prio_valid_q <= 1'b0;
            ip_prio_q <= '0;
        end
        else
        begin
            ip_prio_valid_q <= lookup_dly_q;
            ip_prio_q <= gcfg_q.use_precedence ? prec_dly_q : mem_b_rdata;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gcfg = gcfg_q;
    assign cnt_clear_value = cnt_clear_q;
    assign ip_prio_valid = ip_prio_valid_q;
    assign ip_prio = ip_prio_q;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rd_launch;
        cmd_launch && pwdata[sip_pkg::SIP_CMD_DIR_BIT];
    endsequence

    sequence s_wr_launch;
        cmd_launch && !pwdata[sip_pkg::SIP_CMD_DIR_BIT];
    endsequence

    chk_launch_sets_pending: assert property (cmd_launch |=> prio_pending_q)
        else $error("table command did not raise pending");
    chk_read_dir_path: assert property (s_rd_launch |=> state_q == sip_pkg::SIP_ST_RD_ADDR)
        else $error("read command did not start a read");
    chk_index_captured: assert property (cmd_launch |=> tbl_idx_q == $past(pwdata[5:0]))
        else $error("table index not taken from command");
    chk_write_stores_entry: assert property (s_wr_launch ##1 !cmd_launch |-> mem_we ##1 !prio_pending_q)
        else $error("write did not store then clear pending");
    chk_read_result_ready: assert property (s_rd_launch ##1 !cmd_launch [*2] |=> !prio_pending_q
        && rdata_q == $past(mem_a_rdata))
        else $error("read data not ready when pending cleared");
    chk_vlan_pending_flag: assert property (vlan_cmd_done && !vlan_cmd_start |=> !vlan_pending_q)
        else $error("vlan pending did not self clear");
    chk_lookup_two_cycles: assert property (lookup_valid |-> ##2 ip_prio_valid_q)
        else $error("lookup result not after two cycles");
    chk_prec_select_path: assert property (ip_prio_valid_q && $past(gcfg_q.use_precedence)
        |-> ip_prio_q == $past(lookup_tos[7:5], 2))
        else $error("precedence path gave wrong priority");
    chk_counter_test_value: assert property (gcfg_q.counter_test_mode [*2]
        |-> cnt_clear_q == 32'h07FF_FFFC)
        else $error("counter test value not presented");
endmodule

// >>> tb/tb.sv
// self-checking bench for the ingress priority table control
`timescale 1ns/1ps
module tb;
    typedef struct packed
    {
        logic [31:0] data;
        logic err;
        logic chk;
    } sip_exp_t;

    // byte addresses: four times the register index
    localparam logic [15:0] a_vlan_sts = {sip_pkg::SIP_IDX_VLAN_STS, 2'b00};
    localparam logic [15:0] a_pt_cmd = {sip_pkg::SIP_IDX_PT_CMD, 2'b00};
    localparam logic [15:0] a_pt_wdata = {sip_pkg::SIP_IDX_PT_WDATA, 2'b00};
    localparam logic [15:0] a_pt_rdata = {sip_pkg::SIP_IDX_PT_RDATA, 2'b00};
    localparam logic [15:0] a_pt_sts = {sip_pkg::SIP_IDX_PT_STS, 2'b00};
    localparam logic [15:0] a_gcfg = {sip_pkg::SIP_IDX_GCFG, 2'b00};

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic vlan_cmd_start = 1'b0;
    logic vlan_cmd_done = 1'b0;
    logic lookup_valid = 1'b0;
    logic [7:0] lookup_tos = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ip_prio_valid;
    logic [2:0] ip_prio;
    sip_pkg::sip_gcfg_t gcfg;
    logic [31:0] cnt_clear_value;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] lfsr = 16'hFA20;
    logic [2:0] shadow [64];
    sip_exp_t apb_q[$];
    logic [2:0] prio_q[$];
    sip_exp_t e;
    logic [31:0] rd;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    sip_ctrl i_sip_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vlan_cmd_start(vlan_cmd_start), .vlan_cmd_done(vlan_cmd_done), .lookup_valid(lookup_valid),
        .lookup_tos(lookup_tos), .ip_prio_valid(ip_prio_valid), .ip_prio(ip_prio), .gcfg(gcfg),
        .cnt_clear_value(cnt_clear_value));

    // 16-bit fibonacci shift register, fixed start value
    function automatic void rnd(output logic [15:0] v);
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        v = lfsr;
    endfunction

    task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected word at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic cmp_prio(input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected priority at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd, input logic [31:0] exp,
                       input logic err, input logic chk);
        apb_q.push_back('{exp, err, chk});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; the wait ends when pready is sampled high, the hang guard bounds it
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic rd_chk(input logic [15:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, exp, 1'b0, 1'b1);
    endtask

    // poll the table status until the pending flag drops, bounded
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, a_pt_sts, 32'h0, 32'h0, 1'b0, 1'b0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 10);
        cmp_word(32'h0, rd);
    endtask

    task automatic tbl_write(input logic [5:0] idx, input logic [2:0] p, input logic [28:0] junk);
        wr(a_pt_wdata, {junk, p});
        wr(a_pt_cmd, {24'h0, 2'b00, idx});
        shadow[idx] = p;
        wait_idle();
    endtask

    // bit 6 set on purpose: reserved, must read back as zero
    task automatic tbl_read(input logic [5:0] idx);
        wr(a_pt_cmd, {24'h0, 2'b11, idx});
        wait_idle();
        rd_chk(a_pt_rdata, {29'h0, shadow[idx]});
        rd_chk(a_pt_cmd, {24'h0, 2'b10, idx});
    endtask

    task automatic lookup(input logic [7:0] tos, input logic prec);
        @(posedge pclk);
        lookup_valid <= 1'b1;
        lookup_tos <= tos;
        prio_q.push_back(prec ? tos[7:5] : shadow[tos[7:2]]);
    endtask

    task automatic vlan_pulse(input logic s, input logic d);
        @(posedge pclk);
        vlan_cmd_start <= s;
        vlan_cmd_done <= d;
        @(posedge pclk);
        vlan_cmd_start <= 1'b0;
        vlan_cmd_done <= 1'b0;
    endtask

    // watcher: oldest note against each completed transfer or lookup
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && apb_q.size() > 0)
        begin
            e = apb_q.pop_front();
            cmp_word({31'h0, e.err}, {31'h0, pslverr});
            if (e.chk)
                cmp_word(e.data, prdata);
        end
        if (ip_prio_valid === 1'b1)
        begin
            if (prio_q.size() > 0)
                cmp_prio(prio_q.pop_front(), ip_prio);
            else
            begin
                n_errors++;
                $display("unexpected priority at %0t: expected none got %h", $time, ip_prio);
            end
        end
    end

    // hang guard, far above the fewer than two thousand cycles the run needs
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        logic [15:0] r1;
        logic [15:0] r2;
        logic [31:0] w;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of every register but the read data register
        rd_chk(a_gcfg, 32'h0000_0004);
        rd_chk(a_vlan_sts, 32'h0);
        rd_chk(a_pt_sts, 32'h0);
        rd_chk(a_pt_cmd, 32'h0);
        rd_chk(a_pt_wdata, 32'h0);
        cmp_word(32'h0, cnt_clear_value);
        // config: all ones, all zeros, then random words
        for (int i = 0; i < 8; i++)
        begin
            rnd(r1);
            rnd(r2);
            w = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : {r1, r2};
            wr(a_gcfg, w);
            rd_chk(a_gcfg, w & 32'h0003_FFE4);
            cmp_word({18'h0, w[17:5], w[2]}, {18'h0, gcfg});
            cmp_word(w[6] ? 32'h07FF_FFFC : 32'h0, cnt_clear_value);
        end
        // fill the whole table, upper write-data bits as noise
        for (int i = 0; i < 64; i++)
        begin
            rnd(r1);
            tbl_write(i[5:0], r1[2:0], {r1, 13'h1FFF});
        end
        rd_chk(a_pt_wdata, {29'h0, shadow[63]});
        rd_chk(a_pt_cmd, {24'h0, 8'h3F});
        tbl_read(6'h00);
        tbl_read(6'h3F);
        for (int i = 0; i < 6; i++)
        begin
            rnd(r1);
            tbl_write(r1[5:0], ~shadow[r1[5:0]], 29'h0);
            tbl_read(r1[5:0]);
        end
        // read-only and unmapped places
        wr(a_pt_rdata, 32'hFFFF_FFFF);
        rd_chk(a_pt_rdata, {29'h0, shadow[r1[5:0]]});
        wr(a_vlan_sts, 32'hFFFF_FFFF);
        rd_chk(a_vlan_sts, 32'h0);
        // index 0x1841 is unmapped; config at 0x1840 must stay untouched
        apb(1'b1, 16'h6104, 32'hFFFF_FFFF, 32'h0, 1'b1, 1'b0);
        apb(1'b0, 16'h6042, 32'h0, 32'h0, 1'b1, 1'b0);
        rd_chk(a_gcfg, w & 32'h0003_FFE4);
        // lookups through the table, then through precedence bits
        for (int p = 0; p < 2; p++)
        begin
            wr(a_gcfg, {22'h0, 1'b1, 6'h0, p[0], 2'b00});
            for (int i = 0; i < 16; i++)
            begin
                rnd(r1);
                lookup(r1[7:0], p[0]);
            end
            @(posedge pclk);
            lookup_valid <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        // vlan table pending flag, set wins over clear
        vlan_pulse(1'b1, 1'b0);
        rd_chk(a_vlan_sts, 32'h1);
        vlan_pulse(1'b0, 1'b1);
        rd_chk(a_vlan_sts, 32'h0);
        vlan_pulse(1'b1, 1'b1);
        rd_chk(a_vlan_sts, 32'h1);
        vlan_pulse(1'b0, 1'b1);
        rd_chk(a_vlan_sts, 32'h0);
        repeat (3) @(posedge pclk);
        complete_run();
    end
endmodule
